// ### design/xbar_defs.svh
// constants for the alternate-mode crossbar control logic
`ifndef XBAR_DEFS_SVH
`define XBAR_DEFS_SVH

// target address: fixed upper pattern, two strap bits, rw flag
`define XBAR_ADDR_FIXED     5'h15
`define XBAR_ADDR_W         7
`define XBAR_BYTE_W         8
`define XBAR_BITS_PER_BYTE  4'h8

// register set positions, counted from the first byte after the address
`define XBAR_IDX_W          2
`define XBAR_IDX_ID         2'h0
`define XBAR_IDX_SEL        2'h1
`define XBAR_IDX_LAST       2'h3

// selection register layout and reset
`define XBAR_CODE_W         3
`define XBAR_SEL_RESET      3'h0
`define XBAR_SEL_PAD        5'h00

// identification value: arbitrary, not tied to any maker
`define XBAR_ID_VALUE       8'h5A

// configuration codes
`define XBAR_CODE_OFF       3'h0
`define XBAR_CODE_IDLE      3'h1

// connector pair one-hot: bit0 tx1, bit1 tx2, bit2 rx1, bit3 rx2
`define XBAR_CONN_NONE      4'h0
`define XBAR_CONN_TX1       4'h1
`define XBAR_CONN_TX2       4'h2
`define XBAR_CONN_RX1       4'h4
`define XBAR_CONN_RX2       4'h8

// sideband one-hot: bit0 sbu1, bit1 sbu2
`define XBAR_SBU_NONE       2'h0
`define XBAR_SBU1           2'h1
`define XBAR_SBU2           2'h2

`endif

// ### design/xbar_pkg.sv
// types shared by the crossbar control modules
package xbar_pkg;

  // serial target states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_AACK  = 7'h04,
    ST_WDATA = 7'h08,
    ST_WACK  = 7'h10,
    ST_RDATA = 7'h20,
    ST_RACK  = 7'h40
  } target_state_t;

  // switch enables for every system-side channel
  typedef struct packed {
    logic [3:0] usbTx;
    logic [3:0] usbRx;
    logic [3:0] lane3;
    logic [3:0] lane2;
    logic [3:0] lane1;
    logic [3:0] lane0;
    logic [1:0] auxPos;
    logic [1:0] auxNeg;
    logic       powerDown;
  } route_t;

endpackage

// ### design/regbus_if.sv
// byte access path between the serial target and the register bank
`timescale 1ns/1ps
`default_nettype none
`include "xbar_defs.svh"

interface regbus_if;
  logic                    wrStrobe;
  logic [`XBAR_IDX_W-1:0]  index;
  logic [`XBAR_BYTE_W-1:0] wrData;
  logic [`XBAR_BYTE_W-1:0] rdData;

  modport engine (
    output wrStrobe,
    output index,
    output wrData,
    input  rdData
  );

  modport regs (
    input  wrStrobe,
    input  index,
    input  wrData,
    output rdData
  );
endinterface

`default_nettype wire

// ### design/xbar_reg_bank.sv
// identification and selection bytes behind the serial target
`timescale 1ns/1ps
`default_nettype none
`include "xbar_defs.svh"

module xbar_reg_bank #(
  parameter logic [`XBAR_BYTE_W-1:0] ID_VALUE = `XBAR_ID_VALUE
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  regbus_if.regs                       bus,
  output logic [`XBAR_CODE_W-1:0]      selCode
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic                    hitSel;
  logic [`XBAR_CODE_W-1:0] selCode_d;
  logic [`XBAR_CODE_W-1:0] selCode_q;

  assign hitSel = bus.wrStrobe && (bus.index == `XBAR_IDX_SEL);
  assign selCode_d = hitSel ? bus.wrData[`XBAR_CODE_W-1:0] : selCode_q;

  assign bus.rdData = (bus.index == `XBAR_IDX_ID)  ? ID_VALUE :
                      (bus.index == `XBAR_IDX_SEL) ?
                        {`XBAR_SEL_PAD, selCode_q} : '0;
  assign selCode = selCode_q;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // selection byte store
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      selCode_q <= `XBAR_SEL_RESET;
    end else begin
      selCode_q <= selCode_d;
    end
  end

endmodule

`default_nettype wire

// ### design/xbar_route_decode.sv
// turns a configuration code into crossbar switch enables
`timescale 1ns/1ps
`default_nettype none
`include "xbar_defs.svh"

module xbar_route_decode #(
  parameter bit SINK_MAP = 1'b0
) (
  input  wire logic [`XBAR_CODE_W-1:0] code,
  output xbar_pkg::route_t             route
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // exchange pair 1 and pair 2 for the flipped plug
  function automatic logic [3:0] flipPair(input logic [3:0] c,
                                          input logic       f);
    flipPair = f ? {c[2], c[3], c[0], c[1]} : c;
  endfunction

  function automatic logic [1:0] flipSbu(input logic [1:0] s,
                                         input logic       f);
    flipSbu = f ? {s[0], s[1]} : s;
  endfunction

  // ----------------------------------------------------------------
  // code fields
  // ----------------------------------------------------------------
  logic       flip;
  logic       dpOn;
  logic       usbOn;
  logic       fourLane;
  logic [3:0] base0;
  logic [3:0] base1;
  logic [3:0] base2;
  logic [3:0] base3;
  logic [1:0] basePos;
  logic [1:0] baseNeg;

  assign flip     = code[0];
  assign dpOn     = code[1];
  assign usbOn    = code[2];
  assign fourLane = dpOn && !usbOn;

  assign base0 = SINK_MAP ? `XBAR_CONN_TX2 : `XBAR_CONN_RX2;
  assign base1 = SINK_MAP ? `XBAR_CONN_RX2 : `XBAR_CONN_TX2;
  assign base2 = SINK_MAP ? `XBAR_CONN_RX1 : `XBAR_CONN_TX1;
  assign base3 = SINK_MAP ? `XBAR_CONN_TX1 : `XBAR_CONN_RX1;
  assign basePos = SINK_MAP ? `XBAR_SBU2 : `XBAR_SBU1;
  assign baseNeg = SINK_MAP ? `XBAR_SBU1 : `XBAR_SBU2;

  // ----------------------------------------------------------------
  // switch enables
  // ----------------------------------------------------------------
  // usb pairs follow plug
  assign route.usbTx = usbOn ? flipPair(`XBAR_CONN_TX1, flip)
                             : `XBAR_CONN_NONE;
  assign route.usbRx = usbOn ? flipPair(`XBAR_CONN_RX1, flip)
                             : `XBAR_CONN_NONE;
  assign route.lane0 = dpOn ? flipPair(base0, flip) : `XBAR_CONN_NONE;
  assign route.lane1 = dpOn ? flipPair(base1, flip) : `XBAR_CONN_NONE;
  assign route.lane2 = fourLane ? flipPair(base2, flip) : `XBAR_CONN_NONE;
  assign route.lane3 = fourLane ? flipPair(base3, flip) : `XBAR_CONN_NONE;
  assign route.auxPos = dpOn ? flipSbu(basePos, flip) : `XBAR_SBU_NONE;
  assign route.auxNeg = dpOn ? flipSbu(baseNeg, flip) : `XBAR_SBU_NONE;
  assign route.powerDown = (code == `XBAR_CODE_OFF);

endmodule

`default_nettype wire

// ### design/usbc_altmode_xbar_control.sv
// top of the alternate-mode crossbar control: serial target and routing
//
// Summary of operation
// - select low: pins drive code, level ignored
// - select high: serial control, level pin sets
// - address is 10101, straps, then rw
// - address bits 2 and 1 from straps
// - first register byte: read-only identification
// - second byte: code in 2-0, rest zero
// - serial mode uses register code, same decode
// - 000 opens all, powers down; 001 opens
// - source display lane order per code
// - source two-lane codes drop lanes 2, 3
// - source sideband mapping and flip swap
// - sink display lane order per code
// - sink two-lane codes drop lanes 2, 3
// - sink sideband mapping and flip swap
// - sideband rerouted on flipped plug
`timescale 1ns/1ps
`default_nettype none
`include "xbar_defs.svh"

module usbc_altmode_xbar_control #(
  parameter bit                        SINK_MAP = 1'b0,
  parameter logic [`XBAR_BYTE_W-1:0]   ID_VALUE = `XBAR_ID_VALUE
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    control_source_select,
  input  wire logic                    serial_level_select,
  input  wire logic [`XBAR_CODE_W-1:0] crossbar_config_code,
  input  wire logic                    addr_strap_hi,
  input  wire logic                    addr_strap_lo,
  input  wire logic                    scl,
  input  wire logic                    sdaIn,
  output logic                         sdaOut,
  output logic                         sdaOe,
  output logic                         serialLevelHigh,
  output logic                         powerDown,
  output logic [3:0]                   sys_usb_tx_pair,
  output logic [3:0]                   sys_usb_rx_pair,
  output logic [3:0]                   sys_display_lane0,
  output logic [3:0]                   sys_display_lane1,
  output logic [3:0]                   sys_display_lane2,
  output logic [3:0]                   sys_display_lane3,
  output logic [1:0]                   auxPosSbu,
  output logic [1:0]                   auxNegSbu
);

  // ----------------------------------------------------------------
  // mode and address
  // ----------------------------------------------------------------
  logic                          serialMode;
  logic [`XBAR_ADDR_W-1:0]       myAddr;
  logic                          strapHi_q;
  logic                          strapLo_q;

  assign serialMode = control_source_select;
  assign serialLevelHigh = serialMode && serial_level_select;
  assign myAddr = {`XBAR_ADDR_FIXED, strapHi_q, strapLo_q};

  // straps are static; sampled every clock after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strapHi_q <= 1'b0;
      strapLo_q <= 1'b0;
    end else begin
      strapHi_q <= addr_strap_hi;
      strapLo_q <= addr_strap_lo;
    end
  end

  // ----------------------------------------------------------------
  // bus line edges
  // ----------------------------------------------------------------
  logic sclLast_q;
  logic sdaLast_q;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  // previous line levels for edge and condition detection
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclLast_q <= 1'b1;
      sdaLast_q <= 1'b1;
    end else begin
      sclLast_q <= scl;
      sdaLast_q <= sdaIn;
    end
  end

  // data change while clock high marks start or stop
  assign sclRise   = scl && !sclLast_q;
  assign sclFall   = !scl && sclLast_q;
  assign startSeen = scl && sclLast_q && sdaLast_q && !sdaIn;
  assign stopSeen  = scl && sclLast_q && !sdaLast_q && sdaIn;

  // ----------------------------------------------------------------
  // serial target
  // ----------------------------------------------------------------
  regbus_if bus ();

  xbar_pkg::target_state_t     state_q;
  xbar_pkg::target_state_t     state_d;
  logic [3:0]                  bitCnt_q;
  logic [3:0]                  bitCnt_d;
  logic [`XBAR_BYTE_W-1:0]     shift_q;
  logic [`XBAR_BYTE_W-1:0]     shift_d;
  logic                        rw_q;
  logic                        rw_d;
  logic [`XBAR_IDX_W-1:0]      index_q;
  logic [`XBAR_IDX_W-1:0]      index_d;
  logic [`XBAR_IDX_W-1:0]      indexNext;
  logic                        wrPulse;
  logic                        byteDone;

  // register position saturates past the last byte
  assign indexNext = (index_q == `XBAR_IDX_LAST) ? index_q
                                                 : index_q + 2'h1;
  assign byteDone  = sclFall && (bitCnt_q == `XBAR_BITS_PER_BYTE);

  // next state of the byte engine
  always_comb begin
    state_d  = state_q;
    bitCnt_d = bitCnt_q;
    shift_d  = shift_q;
    rw_d     = rw_q;
    index_d  = index_q;
    wrPulse  = 1'b0;
    if (!serialMode || stopSeen) begin
      // serial bus ignored in pin mode
      state_d = xbar_pkg::ST_IDLE;
    end else if (startSeen) begin
      state_d  = xbar_pkg::ST_ADDR;
      bitCnt_d = 4'h0;
      index_d  = `XBAR_IDX_ID;
    end else begin
      unique case (state_q)
        xbar_pkg::ST_IDLE: begin
          state_d = xbar_pkg::ST_IDLE;
        end
        xbar_pkg::ST_ADDR: begin
          if (sclRise) begin
            shift_d  = {shift_q[6:0], sdaIn};
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (byteDone) begin
            bitCnt_d = 4'h0;
            if (shift_q[7:1] == myAddr) begin
              rw_d    = shift_q[0];
              state_d = xbar_pkg::ST_AACK;
            end else begin
              state_d = xbar_pkg::ST_IDLE;
            end
          end
        end
        xbar_pkg::ST_AACK: begin
          if (sclFall) begin
            if (rw_q) begin
              shift_d = bus.rdData;
              state_d = xbar_pkg::ST_RDATA;
            end else begin
              state_d = xbar_pkg::ST_WDATA;
            end
          end
        end
        xbar_pkg::ST_WDATA: begin
          if (sclRise) begin
            shift_d  = {shift_q[6:0], sdaIn};
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (byteDone) begin
            bitCnt_d = 4'h0;
            wrPulse  = 1'b1;
            state_d  = xbar_pkg::ST_WACK;
          end
        end
        xbar_pkg::ST_WACK: begin
          if (sclFall) begin
            index_d = indexNext;
            state_d = xbar_pkg::ST_WDATA;
          end
        end
        xbar_pkg::ST_RDATA: begin
          if (sclRise) begin
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (byteDone) begin
            bitCnt_d = 4'h0;
            state_d  = xbar_pkg::ST_RACK;
          end else if (sclFall) begin
            shift_d = {shift_q[6:0], 1'b0};
          end
        end
        xbar_pkg::ST_RACK: begin
          if (sclRise) begin
            // not-acknowledge ends the read
            if (sdaIn) begin
              state_d = xbar_pkg::ST_IDLE;
            end else begin
              index_d = indexNext;
            end
          end else if (sclFall) begin
            shift_d = bus.rdData;
            state_d = xbar_pkg::ST_RDATA;
          end
        end
        default: begin
          state_d = xbar_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // byte engine registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= xbar_pkg::ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q  <= 8'h00;
      rw_q     <= 1'b0;
      index_q  <= `XBAR_IDX_ID;
    end else begin
      state_q  <= state_d;
      bitCnt_q <= bitCnt_d;
      shift_q  <= shift_d;
      rw_q     <= rw_d;
      index_q  <= index_d;
    end
  end

  // open-drain data: only ever pull low
  assign sdaOut = 1'b0;
  assign sdaOe  = (state_q == xbar_pkg::ST_AACK) ||
                  (state_q == xbar_pkg::ST_WACK) ||
                  ((state_q == xbar_pkg::ST_RDATA) && !shift_q[7]);

  // register access path
  assign bus.wrStrobe = wrPulse;
  assign bus.index    = index_q;
  assign bus.wrData   = shift_q;

  // ----------------------------------------------------------------
  // registers and routing
  // ----------------------------------------------------------------
  logic [`XBAR_CODE_W-1:0] regCode;
  logic [`XBAR_CODE_W-1:0] activeCode;
  xbar_pkg::route_t        routeDec;
  xbar_pkg::route_t        route_q;

  xbar_reg_bank #(
    .ID_VALUE (ID_VALUE)
  ) u_regs (
    .clock    (clock),
    .rst_n    (rst_n),
    .bus      (bus),
    .selCode  (regCode)
  );

  assign activeCode = serialMode ? regCode : crossbar_config_code;

  xbar_route_decode #(
    .SINK_MAP (SINK_MAP)
  ) u_decode (
    .code     (activeCode),
    .route    (routeDec)
  );

  // switch enables come from flip-flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      route_q <= '{powerDown: 1'b1, default: '0};
    end else begin
      route_q <= routeDec;
    end
  end

  assign powerDown         = route_q.powerDown;
  assign sys_usb_tx_pair   = route_q.usbTx;
  assign sys_usb_rx_pair   = route_q.usbRx;
  assign sys_display_lane0 = route_q.lane0;
  assign sys_display_lane1 = route_q.lane1;
  assign sys_display_lane2 = route_q.lane2;
  assign sys_display_lane3 = route_q.lane3;
  assign auxPosSbu         = route_q.auxPos;
  assign auxNegSbu         = route_q.auxNeg;

endmodule

`default_nettype wire

// ### verif/xbar_control_properties.sv
// checker on the crossbar control top-level ports
`timescale 1ns/1ps
`default_nettype none
module xbar_control_properties #(
  parameter bit SINK_MAP = 1'b0
) (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       control_source_select,
  input wire logic       serial_level_select,
  input wire logic [2:0] crossbar_config_code,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       serialLevelHigh,
  input wire logic       powerDown,
  input wire logic [3:0] sys_usb_tx_pair,
  input wire logic [3:0] sys_usb_rx_pair,
  input wire logic [3:0] sys_display_lane0,
  input wire logic [3:0] sys_display_lane1,
  input wire logic [3:0] sys_display_lane2,
  input wire logic [3:0] sys_display_lane3,
  input wire logic [1:0] auxPosSbu,
  input wire logic [1:0] auxNegSbu
);
  // ----
  // pin code as the route flops saw it
  // ----
  logic       up_q;
  logic       pin_q;
  logic [2:0] code_q;
  // one edge after release the route flops hold a real decode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) up_q <= 1'b0;
    else up_q <= 1'b1;
  end
  // mode and code captured on the same edge as the design
  always_ff @(posedge clock) begin
    pin_q  <= !control_source_select;
    code_q <= crossbar_config_code;
  end
  // expected decode of the captured pin code
  wire        ok     = up_q && pin_q;
  wire        flip   = code_q[0];
  wire        dp     = code_q[1];
  wire [3:0]  usbExp = code_q[2] ? (flip ? 4'h2 : 4'h1) : 4'h0;
  wire [1:0]  auxExp = !dp ? 2'h0 : ((flip ^ SINK_MAP) ? 2'h2 : 2'h1);
  wire [3:0]  srcL0  = dp ? (flip ? 4'h4 : 4'h8) : 4'h0;
  wire [3:0]  snkL0  = dp ? (flip ? 4'h1 : 4'h2) : 4'h0;
  wire [23:0] hsAll  = {sys_usb_tx_pair, sys_usb_rx_pair, sys_display_lane0,
                        sys_display_lane1, sys_display_lane2, sys_display_lane3};
  // ----
  // properties
  // ----
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // level passes only in serial mode
  a_level_gate: assert property (serialLevelHigh ==
    (control_source_select && serial_level_select)) else $error("level wrong");
  a_pin_power: assert property (ok |-> powerDown == (code_q == 3'h0))
    else $error("power-down wrong");
  a_usb_pairs: assert property (ok |-> sys_usb_tx_pair == usbExp &&
    sys_usb_rx_pair == (usbExp << 2)) else $error("usb pairs wrong");
  a_aux_pair: assert property (ok |-> auxPosSbu == auxExp &&
    auxNegSbu == {auxExp[0], auxExp[1]}) else $error("aux pair wrong");
  a_lane_map: assert property (ok |-> sys_display_lane0 ==
    (SINK_MAP ? snkL0 : srcL0) && sys_display_lane1 == (SINK_MAP ? srcL0 :
    snkL0)) else $error("lane 0 or 1 wrong");
  // two-lane codes drop lanes 2 and 3
  a_two_lane: assert property (ok && code_q[2] |->
    sys_display_lane2 == 4'h0 && sys_display_lane3 == 4'h0)
    else $error("lane 2 or 3 not open");
  // open codes leave every path open
  a_open_codes: assert property (ok && code_q[2:1] == 2'h0 |->
    hsAll == 24'h0 && auxPosSbu == 2'h0 && auxNegSbu == 2'h0)
    else $error("open code has a closed path");
  // serial target silent in pin mode
  a_pin_quiet: assert property (!control_source_select [*2] |-> !sdaOe)
    else $error("data driven in pin mode");
  // data pin only ever pulls low
  a_drain_low: assert property (sdaOut == 1'b0)
    else $error("data driven high");
endmodule
bind usbc_altmode_xbar_control xbar_control_properties #(
  .SINK_MAP(SINK_MAP)
) u_xbar_control_properties (
  .clock, .rst_n, .control_source_select, .serial_level_select,
  .crossbar_config_code, .sdaOut, .sdaOe, .serialLevelHigh, .powerDown,
  .sys_usb_tx_pair, .sys_usb_rx_pair, .sys_display_lane0,
  .sys_display_lane1, .sys_display_lane2, .sys_display_lane3,
  .auxPosSbu, .auxNegSbu);
`default_nettype wire

// ### verif/i2c_pd_ctrl_model.sv
// serial controller standing in for the power delivery controller
`timescale 1ns/1ps
`default_nettype none
module i2c_pd_ctrl_model (
  input  wire logic       clock,
  input  wire logic       sdaWire,
  output logic            scl,
  output logic            sdaPullLow,
  output logic            evt,
  output logic      [8:0] evtVal
);
  // ----
  // bus phases
  // ----
  // half period of 125 clocks keeps scl at 400 kHz
  int half = 125;
  // idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sdaPullLow = 1'b0;
    evt = 1'b0;
    evtVal = 9'h000;
  end
  // wait n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // start, also usable as repeated start
  task automatic start();
    sdaPullLow = 1'b0;
    tick(half);
    scl = 1'b1;
    tick(half);
    sdaPullLow = 1'b1;
    tick(half);
    scl = 1'b0;
    tick(1);
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sdaPullLow = 1'b1;
    tick(half);
    scl = 1'b1;
    tick(half);
    sdaPullLow = 1'b0;
    tick(half);
  endtask
  // byte msb first, ninth bit acknowledges; reports the wire
  task automatic xfer(input logic [7:0] d, input logic ninth);
    logic [8:0] w;
    for (int i = 8; i >= 0; i--) begin
      sdaPullLow = !(i > 0 ? d[i-1] : ninth);
      tick(half);
      scl = 1'b1;
      tick(half);
      w[i] = sdaWire;
      scl = 1'b0;
      tick(1);
    end
    evtVal = w;
    evt = 1'b1;
    tick(1);
    evt = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verif/usbc_altmode_xbar_control_tb.sv
// self-checking bench for the crossbar control block
`timescale 1ns/1ps
`default_nettype none
module usbc_altmode_xbar_control_tb;
  // ----
  // signals and expectation queues
  // ----
  localparam bit         SINK   = 1'b0;
  localparam logic [7:0] ID_EXP = 8'hC3; // arbitrary value
  logic        clock;
  logic        rst_n     = 1'b0;
  logic        sel       = 1'b0;
  logic        lvl       = 1'b0;
  logic        strapHi   = 1'b0;
  logic        strapLo   = 1'b0;
  logic        routeTick = 1'b0;
  logic [2:0]  code      = 3'h0;
  logic [7:0]  v;
  int          seed      = 32'h3EA043AC;
  int          bad_count = 0;
  int          compares  = 0;
  logic [8:0]  busQ[$];
  logic [28:0] routeQ[$];
  wire         scl, sdaOut, sdaOe, pullLow, evt, powerDown;
  wire  [8:0]  evtVal;
  wire  [3:0]  uTx, uRx, ln0, ln1, ln2, ln3;
  wire  [1:0]  auxP, auxN;
  wire         sda = !pullLow && (sdaOe ? sdaOut : 1'b1); // pulled up
  wire  [28:0] routeNow = {powerDown, uTx, uRx, ln0, ln1, ln2, ln3, auxP,
                           auxN};
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  usbc_altmode_xbar_control #(.SINK_MAP(SINK), .ID_VALUE(ID_EXP))
  u_usbc_altmode_xbar_control (
    .clock, .rst_n, .control_source_select(sel), .serial_level_select(lvl),
    .crossbar_config_code(code), .addr_strap_hi(strapHi),
    .addr_strap_lo(strapLo), .scl, .sdaIn(sda), .sdaOut, .sdaOe,
    .serialLevelHigh(), .powerDown, .sys_usb_tx_pair(uTx),
    .sys_usb_rx_pair(uRx), .sys_display_lane0(ln0), .sys_display_lane1(ln1),
    .sys_display_lane2(ln2), .sys_display_lane3(ln3), .auxPosSbu(auxP),
    .auxNegSbu(auxN));
  i2c_pd_ctrl_model u_i2c_pd_ctrl_model (
    .clock, .sdaWire(sda), .scl, .sdaPullLow(pullLow), .evt, .evtVal);
  // ----
  // expectations and helpers
  // ----
  // full switch picture for one code
  function automatic logic [28:0] expRoute(input logic [2:0] c);
    logic       f;
    logic [3:0] u, l0, l1, l2, l3;
    logic [1:0] ap;
    f = c[0];
    u = c[2] ? (f ? 4'h2 : 4'h1) : 4'h0;
    l0 = SINK ? (f ? 4'h1 : 4'h2) : (f ? 4'h4 : 4'h8);
    l1 = SINK ? (f ? 4'h4 : 4'h8) : (f ? 4'h1 : 4'h2);
    l2 = SINK ? (f ? 4'h8 : 4'h4) : (f ? 4'h2 : 4'h1);
    l3 = SINK ? (f ? 4'h2 : 4'h1) : (f ? 4'h8 : 4'h4);
    ap = (f ^ SINK) ? 2'h2 : 2'h1;
    if (!c[1]) {l0, l1, ap} = 10'h000;
    if (!c[1] || c[2]) {l2, l3} = 8'h00;
    return {c == 3'h0, u, u << 2, l0, l1, l2, l3, ap, ap[0], ap[1]};
  endfunction
  // address from fixed pattern and straps
  function automatic logic [7:0] adr(input logic rw);
    return {5'h15, strapHi, strapLo, rw};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic cmp(input string what, input logic [28:0] e, g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic expectRoute(input logic [2:0] c);
    routeQ.push_back(expRoute(c));
    cyc(2);
    routeTick = 1'b1;
    cyc(1);
    routeTick = 1'b0;
  endtask
  task automatic put(input logic [7:0] d, input logic nin, input logic [8:0] e);
    busQ.push_back(e);
    u_i2c_pd_ctrl_model.xfer(d, nin);
  endtask
  // address alone, expected to go unanswered
  task automatic probe(input logic [7:0] a);
    u_i2c_pd_ctrl_model.start();
    put(a, 1'b1, {a, 1'b1});
    u_i2c_pd_ctrl_model.stop();
  endtask
  // compare each result with the oldest note when it shows
  always @(posedge clock) begin
    if (evt) cmp("serial byte", busQ.size() ? busQ.pop_front() : 'x, evtVal);
    if (routeTick) cmp("route", routeQ.size() ? routeQ.pop_front() : 'x,
                       routeNow);
  end
  initial begin
    repeat (100000) @(posedge clock);
    bad_count++;
    finish_test();
  end
  // ----
  // main sequence
  // ----
  initial begin
    cyc(16);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      lvl = 1'($random(seed));
      code = i[2:0];
      expectRoute(code);
    end
    probe(adr(1'b0));
    sel = 1'b1;
    expectRoute(3'h0);
    for (int i = 0; i < 4; i++) begin
      {strapHi, strapLo} = i[1:0];
      lvl = 1'($random(seed));
      code = 3'($random(seed));
      v = 8'($random(seed));
      v[2:0] = {i[1:0], i[0]}; // codes 000 011 100 111
      u_i2c_pd_ctrl_model.start();
      put(adr(1'b0), 1'b1, {adr(1'b0), 1'b0});
      put(~v, 1'b1, {~v, 1'b0});
      put(v, 1'b1, {v, 1'b0});
      if (i[0]) u_i2c_pd_ctrl_model.stop();
      expectRoute(v[2:0]);
      u_i2c_pd_ctrl_model.start();
      put(adr(1'b1), 1'b1, {adr(1'b1), 1'b0});
      put(8'hFF, 1'b0, {ID_EXP, 1'b0});
      put(8'hFF, 1'b0, {5'h00, v[2:0], 1'b0});
      put(8'hFF, 1'b1, {8'h00, 1'b1});
      u_i2c_pd_ctrl_model.stop();
      probe(adr(1'b0) ^ 8'h02);
    end
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    expectRoute(3'h0);
    sel = 1'b0;
    code = 3'($random(seed));
    expectRoute(code);
    finish_test();
  end
endmodule
`default_nettype wire
